// File: mscs_sequencer.sv
// Motor starter contact sequencer: start, run, stop, shutdown and trip contacts.
// Assumes synchronous field inputs, one clock, and an AXI4-Lite master.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mscs_sequencer
    import mscs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire mscs_axi_req_t axi_req,
    output mscs_axi_resp_t axi_resp,
    input wire logic run_request_contact,
    input wire mscs_fault_t faults,
    input wire logic voltage_full_reached,
    input wire logic speed_full_reached,
    input wire logic ramp_down_complete,
    input wire logic [CUR_W-1:0] motor_current_pct,
    output logic run_confirm_output,
    output logic motor_energized_output,
    output logic ramp_end_output,
    output logic running_current_monitor,
    output logic overcurrent_indicator,
    output logic breaker_trip_output,
    output logic supply_indicator,
    output logic current_limit_active,
    output logic [BAR_SEGS-1:0] current_bar
);

    // ==========================================================
    // Register bus state
    logic aw_full_reg, aw_full_next;
    logic [11:0] aw_addr_reg, aw_addr_next;
    logic w_full_reg, w_full_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    mscs_mode_t mode_reg, mode_next;
    logic [CUR_W-1:0] threshold_reg, threshold_next;

    // ==========================================================
    // Sequencer state
    mscs_state_t state_reg, state_next;
    logic monitor_shut_reg, monitor_shut_next;
    logic overcur_shut_reg, overcur_shut_next;
    logic overcur_mon_reg, overcur_mon_next;
    logic trip_reg, trip_next;
    logic run_confirm_reg, run_confirm_next;
    logic motor_on_reg, motor_on_next;
    logic ramp_end_reg, ramp_end_next;
    logic mon_out_reg, mon_out_next;
    logic limit_reg, limit_next;
    logic supply_reg;

    // ==========================================================
    // Derived conditions
    logic restart_rise;
    logic ramp_up_done;
    logic overcurrent;
    logic monitor_excess;
    logic trip_blocked;
    logic [31:0] status_word;
    logic [31:0] current_word;

    // Restart detection on the run request
    mscs_restart_detect u_restart (
        .clk_sys(clk_sys),
        .reset(reset),
        .run_request(run_request_contact),
        .restart_rise(restart_rise)
    );

    // Current bar graph while the motor is fed
    mscs_bar_graph u_bar (
        .clk_sys(clk_sys),
        .reset(reset),
        .show(mscs_energized(state_reg)),
        .current_pct(motor_current_pct),
        .segments(current_bar)
    );

    // ==========================================================
    // Read-back words
    assign status_word = {15'h0000, state_reg, trip_reg, overcur_mon_reg, overcur_shut_reg,
                          monitor_shut_reg, limit_reg, mon_out_reg, ramp_end_reg,
                          motor_on_reg, run_confirm_reg, supply_reg, run_request_contact,
                          (state_reg == ST_RUN)};
    assign current_word = {6'h00, current_bar, 6'h00, motor_current_pct};

    // ==========================================================
    // Write channels: address and data in either order
    always_comb begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        mode_next = mode_reg;
        threshold_next = threshold_reg;
        if (axi_req.awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = axi_req.awaddr;
        end
        if (axi_req.wvalid && wready_reg) begin
            w_full_next = 1'b1;
            w_data_next = axi_req.wdata;
            w_strb_next = axi_req.wstrb;
        end
        if (bvalid_reg && axi_req.bready) begin
            bvalid_next = 1'b0;
        end
        // Commit once both halves are held
        if (aw_full_reg && w_full_reg && !bvalid_reg) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (aw_addr_reg)
                REG_CTRL: begin
                    if (w_strb_reg[0]) begin
                        mode_next = w_data_reg[5:0];
                    end
                end
                REG_THRESH: begin
                    // Byte lanes merge, then clamp to span
                    threshold_next = mscs_clamp({w_strb_reg[1] ? w_data_reg[9:8]
                                                               : threshold_reg[9:8],
                                                 w_strb_reg[0] ? w_data_reg[7:0]
                                                               : threshold_reg[7:0]});
                end
                REG_STATUS, REG_CURRENT: begin
                    bresp_next = RESP_OKAY; // Read-only, write ignored
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                end
            endcase
        end
        awready_next = !aw_full_next && !bvalid_next;
        wready_next = !w_full_next && !bvalid_next;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            mode_reg <= MODE_RESET;
            threshold_reg <= THRESH_RESET_PCT;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            mode_reg <= mode_next;
            threshold_reg <= threshold_next;
        end
    end

    // ==========================================================
    // Read channel: data one cycle after the address
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && axi_req.rready) begin
            rvalid_next = 1'b0;
        end
        if (axi_req.arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (axi_req.araddr)
                REG_CTRL: rdata_next = {26'h0000000, mode_reg};
                REG_THRESH: rdata_next = {22'h000000, threshold_reg};
                REG_STATUS: rdata_next = status_word;
                REG_CURRENT: rdata_next = current_word;
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ==========================================================
    // Detections that steer the sequence
    always_comb begin
        ramp_up_done = mode_reg.speed_feedback_select ? speed_full_reached
                                                      : voltage_full_reached;
        overcurrent = mscs_energized(state_reg) && (motor_current_pct > OVERCUR_LIMIT_PCT);
        monitor_excess = (state_reg == ST_RUN) && (motor_current_pct > threshold_reg);
        trip_blocked = mode_reg.bypass_select && ramp_end_reg && (state_reg == ST_RUN);
    end

    // ==========================================================
    // Sequence, latched shutdowns and contact values
    always_comb begin
        state_next = state_reg;
        monitor_shut_next = monitor_shut_reg;
        overcur_shut_next = overcur_shut_reg;
        overcur_mon_next = overcur_mon_reg;
        trip_next = trip_reg || ((|faults) && !trip_blocked);
        case (state_reg)
            ST_IDLE: begin
                if (run_request_contact) begin
                    state_next = ST_RAMP_UP;
                end
            end
            ST_RAMP_UP: begin
                if (overcurrent) begin
                    state_next = ST_SHUTDOWN;
                end else if (!run_request_contact) begin
                    state_next = mode_reg.ramp_down_disable_select ? ST_IDLE
                                                                   : ST_RAMP_DOWN;
                end else if (ramp_up_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (overcurrent) begin
                    state_next = ST_SHUTDOWN;
                end else if (monitor_excess && mode_reg.monitor_trip_select) begin
                    state_next = ST_SHUTDOWN;
                    monitor_shut_next = 1'b1;
                end else if (!run_request_contact) begin
                    state_next = mode_reg.ramp_down_disable_select ? ST_IDLE
                                                                   : ST_RAMP_DOWN;
                end
            end
            ST_RAMP_DOWN: begin
                if (overcurrent) begin
                    state_next = ST_SHUTDOWN;
                end else if (run_request_contact) begin
                    state_next = ST_RAMP_UP;
                end else if (ramp_down_complete) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SHUTDOWN: begin
                if (restart_rise) begin
                    state_next = ST_RAMP_UP;
                    monitor_shut_next = 1'b0;
                    overcur_shut_next = 1'b0;
                    overcur_mon_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Overcurrent latches, optionally on the monitor contact too
        if (overcurrent) begin
            overcur_shut_next = 1'b1;
            overcur_mon_next = mode_reg.overcurrent_ind_select;
        end
        // Breaker trip removes all power
        if (trip_next) begin
            state_next = ST_IDLE;
        end
        run_confirm_next = run_request_contact && !trip_next;
        motor_on_next = mscs_energized(state_next) && mscs_energized(state_reg);
        ramp_end_next = (state_next == ST_RUN);
        mon_out_next = monitor_shut_next || overcur_mon_next ||
                       (!mode_reg.monitor_trip_select && monitor_excess);
        limit_next = mode_reg.current_limit_select &&
                     ((state_next == ST_RAMP_UP) || (state_next == ST_RAMP_DOWN));
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            monitor_shut_reg <= 1'b0;
            overcur_shut_reg <= 1'b0;
            overcur_mon_reg <= 1'b0;
            trip_reg <= 1'b0;
            run_confirm_reg <= 1'b0;
            motor_on_reg <= 1'b0;
            ramp_end_reg <= 1'b0;
            mon_out_reg <= 1'b0;
            limit_reg <= 1'b0;
            supply_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            monitor_shut_reg <= monitor_shut_next;
            overcur_shut_reg <= overcur_shut_next;
            overcur_mon_reg <= overcur_mon_next;
            trip_reg <= trip_next;
            run_confirm_reg <= run_confirm_next;
            motor_on_reg <= motor_on_next;
            ramp_end_reg <= ramp_end_next;
            mon_out_reg <= mon_out_next;
            limit_reg <= limit_next;
            supply_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign run_confirm_output = run_confirm_reg;
    assign motor_energized_output = motor_on_reg;
    assign ramp_end_output = ramp_end_reg;
    assign running_current_monitor = mon_out_reg;
    assign overcurrent_indicator = overcur_shut_reg;
    assign breaker_trip_output = trip_reg;
    assign supply_indicator = supply_reg;
    assign current_limit_active = limit_reg;
    assign axi_resp.awready = awready_reg;
    assign axi_resp.wready = wready_reg;
    assign axi_resp.bvalid = bvalid_reg;
    assign axi_resp.bresp = bresp_reg;
    assign axi_resp.arready = arready_reg;
    assign axi_resp.rvalid = rvalid_reg;
    assign axi_resp.rdata = rdata_reg;
    assign axi_resp.rresp = rresp_reg;

endmodule : mscs_sequencer

// File: mscs_pkg.sv
// Shared constants, types and helpers of the motor starter contact sequencer.
// Assumes one 250 MHz system clock and an AXI4-Lite master with 12-bit addresses.
package mscs_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_THRESH = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_CURRENT = 12'h00c;

    // ==========================================================
    // Bus answers and widths
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CUR_W = 10;
    localparam int BAR_SEGS = 10;

    // ==========================================================
    // Current figures in percent of full-load current
    localparam logic [CUR_W-1:0] THRESH_MIN_PCT = 10'h032;
    localparam logic [CUR_W-1:0] THRESH_MAX_PCT = 10'h190;
    localparam logic [CUR_W-1:0] THRESH_RESET_PCT = 10'h064;
    localparam logic [CUR_W-1:0] OVERCUR_LIMIT_PCT = 10'h1c2;
    localparam logic [CUR_W-1:0] BAR_STEP_PCT = 10'h028;

    // ==========================================================
    // Mode selections, one bit each, bit 5 first
    typedef struct packed {
        logic bypass_select;
        logic current_limit_select;
        logic speed_feedback_select;
        logic overcurrent_ind_select;
        logic monitor_trip_select;
        logic ramp_down_disable_select;
    } mscs_mode_t;
    localparam mscs_mode_t MODE_RESET = 6'h00;

    // Breaker-trip fault detections
    typedef struct packed {
        logic line_unbalanced;
        logic single_phase;
        logic phase_low;
        logic phase_lost;
        logic switch_misfire;
        logic switch_shorted;
    } mscs_fault_t;

    // ==========================================================
    // AXI4-Lite channels, master to slave and back
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } mscs_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mscs_axi_resp_t;

    // ==========================================================
    // Sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RAMP_UP = 5'h02,
        ST_RUN = 5'h04,
        ST_RAMP_DOWN = 5'h08,
        ST_SHUTDOWN = 5'h10
    } mscs_state_t;

    // True while the motor is fed
    function automatic logic mscs_energized(input mscs_state_t st);
        mscs_energized = (st == ST_RAMP_UP) || (st == ST_RUN) || (st == ST_RAMP_DOWN);
    endfunction : mscs_energized

    // Keep a threshold inside its settable span
    function automatic logic [CUR_W-1:0] mscs_clamp(input logic [CUR_W-1:0] v);
        if (v < THRESH_MIN_PCT) begin
            mscs_clamp = THRESH_MIN_PCT;
        end else if (v > THRESH_MAX_PCT) begin
            mscs_clamp = THRESH_MAX_PCT;
        end else begin
            mscs_clamp = v;
        end
    endfunction : mscs_clamp

endpackage : mscs_pkg

// File: mscs_restart_detect.sv
// Open-then-close detector for the run request.
// Assumes the contact input is already synchronous to clk_sys.
`timescale 1ns/1ps
module mscs_restart_detect
    import mscs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run_request,
    output logic restart_rise
);

    logic prev_reg;
    logic prev_next;

    // ==========================================================
    // Previous sample of the request
    always_comb begin
        prev_next = run_request;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // Rise only: open seen, now closed
    assign restart_rise = run_request && !prev_reg;

endmodule : mscs_restart_detect

// File: mscs_bar_graph.sv
// Ten-segment motor current bar graph, registered.
// Assumes current in percent of full-load current.
`timescale 1ns/1ps
module mscs_bar_graph
    import mscs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic show,
    input wire logic [CUR_W-1:0] current_pct,
    output logic [BAR_SEGS-1:0] segments
);

    logic [BAR_SEGS-1:0] seg_reg;
    logic [BAR_SEGS-1:0] seg_next;
    logic [CUR_W-1:0] level;

    // ==========================================================
    // Segment n lit at or above (n+1) steps
    always_comb begin
        seg_next = '0;
        level = BAR_STEP_PCT;
        for (int i = 0; i < BAR_SEGS; i++) begin
            seg_next[i] = show && (current_pct >= level);
            level = CUR_W'(level + BAR_STEP_PCT);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            seg_reg <= '0;
        end else begin
            seg_reg <= seg_next;
        end
    end

    assign segments = seg_reg;

endmodule : mscs_bar_graph

// File: mscs_field_model.sv
// Field wiring model: operator run contact and the motor's ramp feedback.
// Assumes the bench commands the contact; feedback follows motor power.
`timescale 1ns/1ps
module mscs_field_model (
    input wire logic clk_sys,
    input wire logic close_cmd,
    input wire logic motor_energized_output,
    output logic run_request_contact,
    output logic voltage_full_reached,
    output logic speed_full_reached,
    output logic ramp_down_complete
);
    int cnt = 0;
    // ==========
    // Contact follows the operator; speed is full well before voltage
    always @(posedge clk_sys) begin
        run_request_contact <= close_cmd;
        cnt <= (motor_energized_output && run_request_contact == close_cmd) ? cnt + 1 : 0;
        speed_full_reached <= motor_energized_output && run_request_contact && cnt >= 2;
        voltage_full_reached <= motor_energized_output && run_request_contact && cnt >= 8;
        ramp_down_complete <= motor_energized_output && !run_request_contact && cnt >= 6;
    end
endmodule : mscs_field_model

// File: mscs_sequencer_properties.sv
// Concurrent checks on the contact sequencer's field ports.
// Assumes binding into mscs_sequencer; one clock domain.
`timescale 1ns/1ps
module mscs_checker
    import mscs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run_request_contact,
    input wire mscs_fault_t faults,
    input wire logic [CUR_W-1:0] motor_current_pct,
    input wire logic run_confirm_output,
    input wire logic motor_energized_output,
    input wire logic ramp_end_output,
    input wire logic overcurrent_indicator,
    input wire logic breaker_trip_output,
    input wire logic supply_indicator,
    input wire logic [BAR_SEGS-1:0] current_bar
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Segment pattern for a current figure
    function automatic logic [BAR_SEGS-1:0] bar_of(input logic [CUR_W-1:0] c);
        for (int i = 0; i < BAR_SEGS; i++) begin
            bar_of[i] = int'(c) >= int'(BAR_STEP_PCT) * (i + 1);
        end
    endfunction : bar_of
    // ==========
    // Contact and indicator relations
    a_confirm_follows: assert property (!$past(reset) && !breaker_trip_output |->
        run_confirm_output == $past(run_request_contact)) else $error("run confirm mismatch");
    a_stop_opens_end: assert property (!$past(run_request_contact) |-> !ramp_end_output)
        else $error("ramp end held after stop");
    a_end_needs_power: assert property (ramp_end_output |-> motor_energized_output)
        else $error("ramp end without motor power");
    a_power_after_confirm: assert property ($rose(motor_energized_output) |->
        $past(run_confirm_output)) else $error("motor power before confirm");
    a_overcur_shutdown: assert property (motor_energized_output && run_request_contact
        && motor_current_pct > OVERCUR_LIMIT_PCT && !breaker_trip_output && faults == 6'h00
        |=> overcurrent_indicator && !motor_energized_output && !ramp_end_output)
        else $error("overcurrent did not shut down");
    a_overcur_off: assert property (overcurrent_indicator |-> !motor_energized_output)
        else $error("motor powered during overcurrent");
    a_trip_on_fault: assert property (faults != 6'h00 && !ramp_end_output
        |=> breaker_trip_output) else $error("fault did not trip");
    a_trip_sticky: assert property (breaker_trip_output |=> breaker_trip_output
        && !motor_energized_output && !run_confirm_output) else $error("trip released");
    a_supply_lit: assert property (!$past(reset) |-> supply_indicator)
        else $error("supply indicator dark");
    a_bar_tracks: assert property ($past(motor_energized_output) |->
        current_bar == bar_of($past(motor_current_pct))) else $error("bar graph mismatch");
endmodule : mscs_checker

// File: tb_top.sv
// Bench for the contact sequencer: AXI4-Lite tasks and field sequences.
// Assumes the field model answers ramps within a few cycles.
`timescale 1ns/1ps
module tb_top;
    import mscs_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic close_cmd = 1'b0;
    logic run_request_contact, voltage_full_reached, speed_full_reached, ramp_down_complete;
    logic run_confirm_output, motor_energized_output, ramp_end_output, running_current_monitor;
    logic overcurrent_indicator, breaker_trip_output, supply_indicator, current_limit_active;
    logic [BAR_SEGS-1:0] current_bar;
    logic [CUR_W-1:0] cur = 10'h064;
    mscs_fault_t faults = 6'h00;
    mscs_axi_req_t req = '0;
    mscs_axi_resp_t resp;
    logic [31:0] rd;
    logic [1:0] rs;
    int n_errors = 0;
    int n_checks = 0;
    always #2 clk_sys = ~clk_sys;
    mscs_sequencer u_mscs_sequencer (.clk_sys, .reset, .axi_req(req), .axi_resp(resp),
        .run_request_contact, .faults, .voltage_full_reached, .speed_full_reached,
        .ramp_down_complete, .motor_current_pct(cur), .run_confirm_output,
        .motor_energized_output, .ramp_end_output, .running_current_monitor,
        .overcurrent_indicator, .breaker_trip_output, .supply_indicator,
        .current_limit_active, .current_bar);
    mscs_field_model u_mscs_field_model (.clk_sys, .close_cmd, .motor_energized_output,
        .run_request_contact, .voltage_full_reached, .speed_full_reached, .ramp_down_complete);
    // ==========
    // Bus, compare and sequencing tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : step
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
        req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (resp.awready) req.awvalid <= 1'b0;
            if (resp.wready) req.wvalid <= 1'b0;
        end while (!resp.bvalid);
        req.bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [11:0] a);
        @(posedge clk_sys);
        req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (resp.arready) req.arvalid <= 1'b0;
        end while (!resp.rvalid);
        rd = resp.rdata;
        rs = resp.rresp;
        req.rready <= 1'b0;
    endtask : axr
    task automatic rst();
        reset <= 1'b1; close_cmd <= 1'b0; faults <= 6'h00;
        step(12);
        reset <= 1'b0;
        step(2);
    endtask : rst
    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // ==========
    // Watchdog and main sequence
    initial begin
        step(20000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst();
        axr(REG_THRESH); chk("thresh reset", 32'h64, rd);
        axw(REG_THRESH, 32'h1e); axr(REG_THRESH); chk("thresh low", 32'h32, rd);
        axw(REG_THRESH, 32'h1f4); axr(REG_THRESH); chk("thresh high", 32'h190, rd);
        axw(REG_THRESH, 32'h96); axr(12'h010); chk("unmapped", 32'h2, 32'(rs));
        close_cmd <= 1'b1; step(9);
        chk("start", 32'h1, {ramp_end_output, motor_energized_output});
        step(7); chk("run", 32'h5, {ramp_end_output, current_limit_active, 1'b1});
        cur <= 10'h0c8; step(3);
        chk("excess", 32'h3, {running_current_monitor, motor_energized_output});
        cur <= 10'h064; step(3);
        chk("excess gone", 32'h0, 32'(running_current_monitor));
        axw(REG_CTRL, 32'h02); axr(REG_CTRL); chk("ctrl", 32'h02, rd);
        cur <= 10'h0c8; step(3); cur <= 10'h064;
        chk("mon trip", 32'h9, {running_current_monitor, motor_energized_output,
            ramp_end_output, run_confirm_output});
        close_cmd <= 1'b0; step(3); close_cmd <= 1'b1; step(16);
        chk("restart", 32'h3, {running_current_monitor, motor_energized_output,
            ramp_end_output});
        axw(REG_CTRL, 32'h04); cur <= 10'h1cc; step(3); cur <= 10'h064;
        chk("overcur", 32'h6, {overcurrent_indicator, running_current_monitor,
            motor_energized_output});
        close_cmd <= 1'b0; step(3); close_cmd <= 1'b1; step(16);
        chk("oc restart", 32'h1, {overcurrent_indicator, motor_energized_output});
        axw(REG_CTRL, 32'h01); close_cmd <= 1'b0; step(3);
        chk("fast stop", 32'h0, {run_confirm_output, ramp_end_output,
            motor_energized_output});
        axw(REG_CTRL, 32'h00); close_cmd <= 1'b1; step(16); close_cmd <= 1'b0; step(3);
        chk("ramp down", 32'h1, {ramp_end_output, motor_energized_output});
        step(10); chk("ramp down end", 32'h0, 32'(motor_energized_output));
        axw(REG_CTRL, 32'h38); close_cmd <= 1'b1; step(5);
        chk("limit ramp", 32'h1, {ramp_end_output, current_limit_active});
        step(4); chk("speed end", 32'h2, {ramp_end_output, current_limit_active});
        step(7); faults <= 6'h01; step(3);
        chk("bypass run", 32'h0, 32'(breaker_trip_output));
        close_cmd <= 1'b0; step(4);
        chk("bypass stop", 32'h1, 32'(breaker_trip_output));
        for (int i = 0; i < 6; i++) begin
            rst(); faults <= mscs_fault_t'(6'h01 << i); step(3);
            chk("fault trip", 32'h1, 32'(breaker_trip_output));
        end
        report_and_stop();
    end
endmodule : tb_top
bind mscs_sequencer mscs_checker u_mscs_checker (.clk_sys, .reset, .run_request_contact,
    .faults, .motor_current_pct, .run_confirm_output, .motor_energized_output,
    .ramp_end_output, .overcurrent_indicator, .breaker_trip_output, .supply_indicator,
    .current_bar);
